// ==== inc/dlr_pkg.sv ====
// shared constants and carrier types for the dual-load relay card register bank
package dlr_pkg;

   // clock and relay settle times
   localparam int CLK_MHZ      = 100;
   localparam int ARM_TIME_US  = 16000;
   localparam int REED_TIME_US = 500;
   localparam int ARM_CYCLES   = ARM_TIME_US * CLK_MHZ;
   localparam int REED_CYCLES  = REED_TIME_US * CLK_MHZ;

   // bus widths and responses
   localparam int         AXIL_ADDR_W = 8;
   localparam int         IDX_W       = AXIL_ADDR_W - 2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CARD_TYPE_ID     = 6'h0;
   localparam logic [IDX_W-1:0] IDX_STRAP_CONFIG     = 6'h1;
   localparam logic [IDX_W-1:0] IDX_STATUS_STRAP     = 6'h2;
   localparam logic [IDX_W-1:0] IDX_SENSE_SELECT     = 6'h3;
   localparam logic [IDX_W-1:0] IDX_LOAD_CONNECT_LO  = 6'h4;
   localparam logic [IDX_W-1:0] IDX_LOAD_CONNECT_HI  = 6'h5;
   localparam logic [IDX_W-1:0] IDX_PULLUP_POWER_LO  = 6'h6;
   localparam logic [IDX_W-1:0] IDX_PULLUP_POWER_HI  = 6'h7;
   localparam logic [IDX_W-1:0] IDX_LOAD_CHOICE_LO   = 6'h8;
   localparam logic [IDX_W-1:0] IDX_LOAD_CHOICE_HI   = 6'h9;
   localparam logic [IDX_W-1:0] IDX_LAST             = 6'h9;

   // field layout
   localparam int         NUM_CH          = 16;
   localparam int         BANK_W          = 8;
   localparam int         SENSE_CODE_W    = 5;
   localparam int         DIFFAMP_BIT     = 7;
   localparam int         READY_BIT       = 0;
   localparam int         STRAP_HIGH_BIT  = 8;
   localparam logic [6:0] STATUS_ONES     = 7'h7f;
   // card type value is arbitrary
   localparam logic [7:0] CARD_TYPE_VALUE = 8'h5a;

   // reset values
   localparam logic [NUM_CH-1:0] RELAYS_RESET = 16'h0000;

   // axi4-lite request from the master
   typedef struct packed {
      logic [AXIL_ADDR_W-1:0] awaddr;
      logic                   awvalid;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   wvalid;
      logic                   bready;
      logic [AXIL_ADDR_W-1:0] araddr;
      logic                   arvalid;
      logic                   rready;
   } dlr_axil_req_type;

   // axi4-lite answer from the slave
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dlr_axil_rsp_type;

endpackage

// ==== core/dlr_relay_timer.sv ====
// retriggerable relay settle timer
`timescale 1ns/100ps
module dlr_relay_timer #(
   parameter int CYCLES = 1
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // control
   input  wire logic restart,
   // status
   output logic      busy
);
   import dlr_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          busy;
   } dlr_timer_state_type;

   dlr_timer_state_type state_ff;
   dlr_timer_state_type nxt_state;

   // elaboration check on the count
   if (CYCLES < 1) begin : g_bad_cycles
      $error("relay timer needs at least one cycle");
   end

   // reload on restart, otherwise run down to zero
   always_comb begin
      nxt_state = state_ff;
      if (restart) begin
         nxt_state.cnt = CW'(CYCLES);
      end else if (state_ff.cnt != '0) begin
         nxt_state.cnt = state_ff.cnt - CW'(1);
      end
      nxt_state.busy = (nxt_state.cnt != '0);
   end

   // card reset also restarts the timer
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_ff.cnt  <= CW'(CYCLES);
         state_ff.busy <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign busy = state_ff.busy;

   // checks on the timer
   AST_TIMER_RELOAD: assert property (@(posedge clk_sys) disable iff (!nrst)
      restart |=> busy && state_ff.cnt == CW'(CYCLES))
      else $error("timer did not reload on restart");

   AST_TIMER_EXPIRE: assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(busy) |-> $past(state_ff.cnt) == CW'(1) && !$past(restart))
      else $error("timer expired early");

   AST_TIMER_QUIET: assert property (@(posedge clk_sys) disable iff (!nrst)
      !busy && !restart |=> !busy)
      else $error("timer went busy without restart");

endmodule

// ==== core/dlr_sense_decode.sv ====
// decoder from sense channel code to one-hot channel select
`timescale 1ns/100ps
module dlr_sense_decode (
   // encoded channel
   input  wire logic [dlr_pkg::SENSE_CODE_W-1:0] sense_channel_code,
   // one-hot channel select
   output logic      [dlr_pkg::NUM_CH-1:0]       channel_onehot
);
   import dlr_pkg::*;

   // code k selects channel k, codes 0 and above 16 select nothing
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      assign channel_onehot[i] = (sense_channel_code == SENSE_CODE_W'(i + 1));
   end

endmodule

// ==== core/dlr_card_regs.sv ====
// register bank and relay drive of the dual-load relay card
`timescale 1ns/100ps
module dlr_card_regs #(
   parameter int ARM_CYCLES  = dlr_pkg::ARM_CYCLES,
   parameter int REED_CYCLES = dlr_pkg::REED_CYCLES
) (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     nrst,
   // register bus
   input  wire dlr_pkg::dlr_axil_req_type axil_req,
   output dlr_pkg::dlr_axil_rsp_type     axil_rsp,
   // configuration straps
   input  wire logic [7:0]               strap_bits_low,
   input  wire logic                     strap_bit_high,
   // sense path
   output logic      [15:0]              sense_channel_onehot,
   output logic                          diffamp_path_select,
   // relay drive per channel
   output logic      [15:0]              load_connect,
   output logic      [15:0]              pullup_power,
   output logic      [15:0]              load_choice
);
   import dlr_pkg::*;

   typedef struct packed {
      logic                   aw_full;
      logic [AXIL_ADDR_W-1:0] aw_addr;
      logic                   w_full;
      logic [BANK_W-1:0]      w_byte;
      logic                   w_en;
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   arready;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      logic [NUM_CH-1:0]      sense_onehot;
      logic                   diffamp;
      logic [NUM_CH-1:0]      load_connect;
      logic [NUM_CH-1:0]      pullup_power;
      logic [NUM_CH-1:0]      load_choice;
      logic                   reed_restart;
      logic                   arm_restart;
   } dlr_regs_state_type;

   dlr_regs_state_type state_ff;
   dlr_regs_state_type nxt_state;

   logic                    arm_busy;
   logic                    reed_busy;
   logic [NUM_CH-1:0]       decoded_onehot;
   logic                    wr_go;
   logic                    wr_hit;
   logic [IDX_W-1:0]        wr_idx;
   logic                    rd_go;
   logic                    rd_hit;
   logic [IDX_W-1:0]        rd_idx;

   // elaboration check on the timer counts
   if (ARM_CYCLES < 1 || REED_CYCLES < 1) begin : g_bad_counts
      $error("relay timer counts must be at least one");
   end

   // armature relay timer
   dlr_relay_timer #(
      .CYCLES (ARM_CYCLES)
   ) u_arm_timer (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .restart (state_ff.arm_restart),
      .busy    (arm_busy)
   );

   // reed relay timer
   dlr_relay_timer #(
      .CYCLES (REED_CYCLES)
   ) u_reed_timer (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .restart (state_ff.reed_restart),
      .busy    (reed_busy)
   );

   // sense channel decoder on the held write byte
   dlr_sense_decode u_sense_decode (
      .sense_channel_code (state_ff.w_byte[SENSE_CODE_W-1:0]),
      .channel_onehot     (decoded_onehot)
   );

   // address decode of the held write and the incoming read
   assign wr_go  = state_ff.aw_full && state_ff.w_full && !state_ff.bvalid;
   assign wr_idx = state_ff.aw_addr[AXIL_ADDR_W-1:2];
   assign wr_hit = (state_ff.aw_addr[1:0] == 2'h0) && (wr_idx <= IDX_LAST);
   assign rd_go  = axil_req.arvalid && state_ff.arready;
   assign rd_idx = axil_req.araddr[AXIL_ADDR_W-1:2];
   assign rd_hit = (axil_req.araddr[1:0] == 2'h0) && (rd_idx <= IDX_LAST);

   // bus slave and register next state
   always_comb begin
      nxt_state              = state_ff;
      nxt_state.reed_restart = 1'b0;
      nxt_state.arm_restart  = 1'b0;

      // write response retires
      if (state_ff.bvalid && axil_req.bready) begin
         nxt_state.bvalid = 1'b0;
      end

      // commit a write once address and data are both held
      if (wr_go) begin
         nxt_state.aw_full = 1'b0;
         nxt_state.w_full  = 1'b0;
         nxt_state.bvalid  = 1'b1;
         nxt_state.bresp   = wr_hit ? RESP_OKAY : RESP_DECERR;
         if (wr_hit && state_ff.w_en) begin
            case (wr_idx)
               IDX_SENSE_SELECT: begin
                  nxt_state.sense_onehot = decoded_onehot;
                  nxt_state.diffamp      = state_ff.w_byte[DIFFAMP_BIT];
                  nxt_state.reed_restart = 1'b1;
               end
               IDX_LOAD_CONNECT_LO: begin
                  nxt_state.load_connect[7:0] = state_ff.w_byte;
                  nxt_state.arm_restart       = 1'b1;
               end
               IDX_LOAD_CONNECT_HI: begin
                  nxt_state.load_connect[15:8] = state_ff.w_byte;
                  nxt_state.arm_restart        = 1'b1;
               end
               IDX_PULLUP_POWER_LO: begin
                  nxt_state.pullup_power[7:0] = state_ff.w_byte;
                  nxt_state.arm_restart       = 1'b1;
               end
               IDX_PULLUP_POWER_HI: begin
                  nxt_state.pullup_power[15:8] = state_ff.w_byte;
                  nxt_state.arm_restart        = 1'b1;
               end
               IDX_LOAD_CHOICE_LO: begin
                  nxt_state.load_choice[7:0] = state_ff.w_byte;
                  nxt_state.arm_restart      = 1'b1;
               end
               IDX_LOAD_CHOICE_HI: begin
                  nxt_state.load_choice[15:8] = state_ff.w_byte;
                  nxt_state.arm_restart       = 1'b1;
               end
               default: begin
                  // read-only offsets ignore writes
               end
            endcase
         end
      end

      // capture write address and write data independently
      if (axil_req.awvalid && state_ff.awready) begin
         nxt_state.aw_full = 1'b1;
         nxt_state.aw_addr = axil_req.awaddr;
      end
      if (axil_req.wvalid && state_ff.wready) begin
         nxt_state.w_full = 1'b1;
         nxt_state.w_byte = axil_req.wdata[BANK_W-1:0];
         nxt_state.w_en   = axil_req.wstrb[0];
      end
      nxt_state.awready = !nxt_state.aw_full && !nxt_state.bvalid;
      nxt_state.wready  = !nxt_state.w_full && !nxt_state.bvalid;

      // read data retires
      if (state_ff.rvalid && axil_req.rready) begin
         nxt_state.rvalid  = 1'b0;
         nxt_state.arready = 1'b1;
      end

      // read answer, write-only offsets read zero
      if (rd_go) begin
         nxt_state.arready = 1'b0;
         nxt_state.rvalid  = 1'b1;
         nxt_state.rresp   = rd_hit ? RESP_OKAY : RESP_DECERR;
         nxt_state.rdata   = 32'h0;
         if (rd_hit) begin
            case (rd_idx)
               IDX_CARD_TYPE_ID: begin
                  nxt_state.rdata[7:0] = CARD_TYPE_VALUE;
               end
               IDX_STRAP_CONFIG: begin
                  nxt_state.rdata[7:0] = strap_bits_low;
               end
               IDX_STATUS_STRAP: begin
                  nxt_state.rdata[7:1]            = STATUS_ONES;
                  nxt_state.rdata[READY_BIT]      = !(arm_busy || reed_busy);
                  nxt_state.rdata[STRAP_HIGH_BIT] = strap_bit_high;
               end
               default: begin
                  nxt_state.rdata = 32'h0;
               end
            endcase
         end
      end
   end

   // registered state, relays open and nothing selected at reset
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_ff              <= '0;
         state_ff.awready      <= 1'b1;
         state_ff.wready       <= 1'b1;
         state_ff.arready      <= 1'b1;
         state_ff.sense_onehot <= RELAYS_RESET;
         state_ff.diffamp      <= 1'b0;
         state_ff.load_connect <= RELAYS_RESET;
         state_ff.pullup_power <= RELAYS_RESET;
         state_ff.load_choice  <= RELAYS_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs straight from the state register
   assign axil_rsp.awready     = state_ff.awready;
   assign axil_rsp.wready      = state_ff.wready;
   assign axil_rsp.bvalid      = state_ff.bvalid;
   assign axil_rsp.bresp       = state_ff.bresp;
   assign axil_rsp.arready     = state_ff.arready;
   assign axil_rsp.rvalid      = state_ff.rvalid;
   assign axil_rsp.rdata       = state_ff.rdata;
   assign axil_rsp.rresp       = state_ff.rresp;
   assign sense_channel_onehot = state_ff.sense_onehot;
   assign diffamp_path_select  = state_ff.diffamp;
   assign load_connect         = state_ff.load_connect;
   assign pullup_power         = state_ff.pullup_power;
   assign load_choice          = state_ff.load_choice;

   // named steps of a committed relay write and of a status read
   sequence seq_reed_write;
      wr_go && wr_hit && state_ff.w_en && wr_idx == IDX_SENSE_SELECT;
   endsequence

   sequence seq_arm_write;
      wr_go && wr_hit && state_ff.w_en
         && wr_idx >= IDX_LOAD_CONNECT_LO && wr_idx <= IDX_LOAD_CHOICE_HI;
   endsequence

   sequence seq_status_read;
      rd_go && rd_hit && rd_idx == IDX_STATUS_STRAP;
   endsequence

   AST_CARD_TYPE: assert property (@(posedge clk_sys) disable iff (!nrst)
      rd_go && rd_hit && rd_idx == IDX_CARD_TYPE_ID |=> axil_rsp.rvalid
         && axil_rsp.rdata == {24'h0, CARD_TYPE_VALUE})
      else $error("card type read wrong");

   AST_STRAP_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
      rd_go && rd_hit && rd_idx == IDX_STRAP_CONFIG |=>
         axil_rsp.rdata[7:0] == $past(strap_bits_low))
      else $error("strap byte read wrong");

   AST_STATUS_BITS: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_status_read |=> axil_rsp.rdata[7:1] == STATUS_ONES
         && axil_rsp.rdata[0] == !$past(arm_busy || reed_busy))
      else $error("status read wrong");

   AST_STRAP_HIGH: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_status_read |=> axil_rsp.rdata[STRAP_HIGH_BIT] == $past(strap_bit_high))
      else $error("ninth strap bit read wrong");

   AST_REED_BUSY: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_reed_write ##1 1'b1 |=> reed_busy)
      else $error("sense write did not start reed timer");

   AST_ARM_BUSY: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_arm_write ##1 1'b1 |=> arm_busy)
      else $error("relay write did not start armature timer");

   AST_SENSE_DECODE: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_reed_write |=> sense_channel_onehot == (($past(state_ff.w_byte[4:0]) >= 5'h01
         && $past(state_ff.w_byte[4:0]) <= 5'h10)
         ? (16'h0001 << ($past(state_ff.w_byte[4:0]) - 5'h01)) : 16'h0000)
         && diffamp_path_select == $past(state_ff.w_byte[DIFFAMP_BIT]))
      else $error("sense select decode wrong");

   AST_LOAD_CONNECT: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_go && wr_hit && state_ff.w_en && wr_idx == IDX_LOAD_CONNECT_LO |=>
         load_connect[7:0] == $past(state_ff.w_byte) && axil_rsp.bvalid)
      else $error("load connect low not written");

   AST_RESET_OPEN: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(!nrst) |-> load_connect == 16'h0 && pullup_power == 16'h0
         && load_choice == 16'h0 && sense_channel_onehot == 16'h0 && !diffamp_path_select)
      else $error("relays not open after reset");

   AST_LOAD_CONNECT_HI: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_go && wr_hit && state_ff.w_en && wr_idx == IDX_LOAD_CONNECT_HI |=>
         load_connect[15:8] == $past(state_ff.w_byte))
      else $error("load connect high not written");

   AST_POWER_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_go && wr_hit && state_ff.w_en && wr_idx == IDX_PULLUP_POWER_LO |=>
         pullup_power[7:0] == $past(state_ff.w_byte))
      else $error("power select low not written");

   AST_POWER_HIGH: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_go && wr_hit && state_ff.w_en && wr_idx == IDX_PULLUP_POWER_HI |=>
         pullup_power[15:8] == $past(state_ff.w_byte))
      else $error("power select high not written");

   AST_CHOICE_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_go && wr_hit && state_ff.w_en && wr_idx == IDX_LOAD_CHOICE_LO |=>
         load_choice[7:0] == $past(state_ff.w_byte))
      else $error("load choice low not written");

   AST_CHOICE_HIGH: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_go && wr_hit && state_ff.w_en && wr_idx == IDX_LOAD_CHOICE_HI |=>
         load_choice[15:8] == $past(state_ff.w_byte))
      else $error("load choice high not written");

   // refused or masked writes must leave every relay where it was
   AST_WRITE_IGNORED: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_go && !(wr_hit && state_ff.w_en) |=> $stable(load_connect) && $stable(pullup_power)
         && $stable(load_choice) && $stable(sense_channel_onehot))
      else $error("ignored write changed a relay");

endmodule

// ==== dv/dlr_host_model.sv ====
// host-side bus master model for the relay card register bank
`timescale 1ns/100ps
module dlr_host_model (
   // clock
   input  wire logic                      clk_sys,
   // register bus
   output dlr_pkg::dlr_axil_req_type      req,
   input  wire dlr_pkg::dlr_axil_rsp_type rsp,
   // a bounded wait ran out
   output logic                           timed_out
);
   import dlr_pkg::*;

   // bus idle at time zero
   initial begin
      req = '0;
      timed_out = 1'b0;
   end

   // one write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] resp);
      int   n;
      logic aw;
      logic w;
      @(posedge clk_sys);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= s;
      req.wvalid <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      for (n = 0; n < 50 && (aw || w); n++) begin
         @(posedge clk_sys);
         if (aw && rsp.awready) begin
            aw = 1'b0;
            req.awvalid <= 1'b0;
         end
         if (w && rsp.wready) begin
            w = 1'b0;
            req.wvalid <= 1'b0;
         end
      end
      // a slow host lets the response wait a little
      repeat ($urandom_range(2, 0)) @(posedge clk_sys);
      req.bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (rsp.bvalid) break;
      end
      resp = rsp.bresp;
      req.bready <= 1'b0;
      if (n >= 50 || aw || w) timed_out = 1'b1;
   endtask

   // one read: address held until taken, data taken at the handshake edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      @(posedge clk_sys);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (rsp.arready) break;
      end
      req.arvalid <= 1'b0;
      if (n >= 50) timed_out = 1'b1;
      repeat ($urandom_range(2, 0)) @(posedge clk_sys);
      req.rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (rsp.rvalid) break;
      end
      d = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
      if (n >= 50) timed_out = 1'b1;
   endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the relay card register bank
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tb;
   import dlr_pkg::*;
   localparam int ARM  = 40;
   localparam int REED = 10;
   logic             clk_sys = 1'b0;
   logic             nrst = 1'b0;
   dlr_axil_req_type req;
   dlr_axil_rsp_type rsp;
   logic [7:0]       strap_lo = 8'hff;
   logic             strap_hi = 1'b1;
   logic [15:0]      onehot;
   logic [15:0]      conn;
   logic [15:0]      pwr;
   logic [15:0]      choice;
   logic             diffamp;
   logic             tmo;
   logic [7:0]       sh [4:9] = '{default: 8'h00};
   logic [31:0]      rdat;
   logic [1:0]       rr;
   logic [7:0]       d;
   int               i;
   int               fail_count = 0;
   int               check_count = 0;

   // clock and watchdog
   always #5 clk_sys = ~clk_sys;
   initial begin
      repeat (100000) @(posedge clk_sys);
      fail_count++;
      finish_test();
   end

   dlr_host_model host (.clk_sys(clk_sys), .req(req), .rsp(rsp), .timed_out(tmo));

   dlr_card_regs #(.ARM_CYCLES(ARM), .REED_CYCLES(REED)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .axil_req(req), .axil_rsp(rsp),
      .strap_bits_low(strap_lo), .strap_bit_high(strap_hi),
      .sense_channel_onehot(onehot), .diffamp_path_select(diffamp),
      .load_connect(conn), .pullup_power(pwr), .load_choice(choice));

   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic guard();
      if (tmo) begin
         fail_count++;
         finish_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s,
                     input logic [1:0] er);
      host.wr(a, {24'h0, v}, s, rr);
      guard();
      `CHK("bresp", er, rr)
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      host.rd(a, rdat, rr);
      guard();
      `CHK("rresp", er, rr)
      `CHK("rdata", ed, rdat)
   endtask

   // relay outputs against the shadow of written bytes
   task automatic chk_relays();
      `CHK("load_connect", {sh[5], sh[4]}, conn)
      `CHK("pullup_power", {sh[7], sh[6]}, pwr)
      `CHK("load_choice", {sh[9], sh[8]}, choice)
   endtask

   // host polls the ready flag before trusting relay state
   task automatic wait_ready();
      int n;
      for (n = 0; n < 60; n++) begin
         host.rd(8'h08, rdat, rr);
         guard();
         if (rdat[READY_BIT] === 1'b1) break;
      end
      `CHK("ready_poll", 1'b0, n >= 60)
      // a poll that never sees ready ends the run
      if (n >= 60) begin
         finish_test();
      end
   endtask

   function automatic logic [15:0] exp_sel(input logic [4:0] c);
      exp_sel = (c >= 5'h01 && c <= 5'h10) ? 16'h0001 << (c - 5'h01) : 16'h0000;
   endfunction

   function automatic logic [31:0] exp_stat(input logic rdy);
      exp_stat = {23'h0, strap_hi, 7'h7f, rdy};
   endfunction

   // main sequence
   initial begin
      void'($urandom(40222));
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      chk_relays();
      `CHK("sense_sel", 16'h0000, onehot)
      `CHK("diffamp", 1'b0, diffamp)
      rd(8'h00, {24'h0, CARD_TYPE_VALUE}, RESP_OKAY);
      rd(8'h04, 32'h0000_00ff, RESP_OKAY);
      rd(8'h08, exp_stat(1'b0), RESP_OKAY);
      strap_lo <= 8'($urandom);
      strap_hi <= 1'($urandom);
      @(posedge clk_sys);
      rd(8'h04, {24'h0, strap_lo}, RESP_OKAY);
      wait_ready();
      rd(8'h08, exp_stat(1'b1), RESP_OKAY);
      $display("test reset_and_id done");

      // every sense code, amplifier bit at random
      for (i = 0; i < 32; i++) begin
         d = {1'($urandom), 2'b11, 5'(i)};
         wr(8'h0c, d, 4'h1, RESP_OKAY);
         `CHK("sense_sel", exp_sel(5'(i)), onehot)
         `CHK("diffamp", d[DIFFAMP_BIT], diffamp)
      end
      wait_ready();
      wr(8'h0c, 8'h81, 4'h1, RESP_OKAY);
      rd(8'h08, exp_stat(1'b0), RESP_OKAY);
      repeat (REED + 5) @(posedge clk_sys);
      rd(8'h08, exp_stat(1'b1), RESP_OKAY);
      $display("test sense_select done");

      // each relay bank written, armature timer outlasts the reed time
      for (i = 4; i < 10; i++) begin
         wait_ready();
         d = 8'($urandom);
         sh[i] = d;
         wr(8'(i * 4), d, 4'h1, RESP_OKAY);
         chk_relays();
         repeat (REED + 5) @(posedge clk_sys);
         rd(8'h08, exp_stat(1'b0), RESP_OKAY);
      end
      $display("test relay_banks done");

      // refused and ignored accesses change nothing
      wait_ready();
      wr(8'h10, 8'h5c, 4'h0, RESP_OKAY);
      wr(8'h28, 8'hff, 4'h1, RESP_DECERR);
      wr(8'h11, 8'hff, 4'h1, RESP_DECERR);
      wr(8'h00, 8'h00, 4'h1, RESP_OKAY);
      chk_relays();
      rd(8'h08, exp_stat(1'b1), RESP_OKAY);
      rd(8'h00, {24'h0, CARD_TYPE_VALUE}, RESP_OKAY);
      for (i = 3; i < 10; i++) rd(8'(i * 4), 32'h0, RESP_OKAY);
      host.rd(8'h28, rdat, rr);
      guard();
      `CHK("rresp", RESP_DECERR, rr)
      $display("test refusals done");

      // reset in mid-run opens every relay and restarts the timers
      wr(8'h18, 8'ha5, 4'h1, RESP_OKAY);
      wr(8'h0c, 8'h83, 4'h1, RESP_OKAY);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      sh = '{default: 8'h00};
      @(posedge clk_sys);
      chk_relays();
      `CHK("sense_sel", 16'h0000, onehot)
      `CHK("diffamp", 1'b0, diffamp)
      rd(8'h08, exp_stat(1'b0), RESP_OKAY);
      wait_ready();
      $display("test mid_reset done");
      finish_test();
   end
endmodule
